// >>> verilog/pfs_top.sv
// Channel 3 current-limit and A/B fault source selection with register port and interrupt
//
// Decided for this implementation: strobed register access.
module pfs_top
  import pfs_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic PEAK_CURRENT_DET,
  input wire logic [3:0] DIGITAL_CMP,
  input wire logic [3:0] EXT_FAULT_IN,
  input wire logic [6:0] ANALOG_CMP,
  output logic CLIM_TRIG,
  output logic FAULT_AB_TRIG,
  output logic IRQ
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [CLIM_W-1:0] clim_sel;
  logic [AB_W-1:0] ab_sel;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic [11:0] async_raw;
  logic [11:0] async_sync;
  logic peak_s;
  logic [3:0] fault_s;
  logic [6:0] acmp_s;
  logic clim_hit;
  logic ab_hit;
  logic [INT_W-1:0] int_event;
  logic [INT_W-1:0] int_clear;
  logic wr_clim;
  logic wr_ab;
  logic wr_status;
  logic wr_mask;
  logic [31:0] next_rdata;
  logic clim_written;
  logic ab_written;

  //////////////////////////////////////////////////////////////////////////////
  // Input conditioning

  // Pins and analog results come from outside the clock domain
  assign async_raw = {PEAK_CURRENT_DET, EXT_FAULT_IN, ANALOG_CMP};

  pfs_sync #(
    .W(12)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .din(async_raw),
    .dout(async_sync)
  );

  // Split the filtered bundle back into its sources
  assign peak_s = async_sync[11];
  assign fault_s = async_sync[10:7];
  assign acmp_s = async_sync[6:0];

  // Digital comparators share the clock and need no synchroniser
  pfs_src_if src_bus ();
  assign src_bus.peak = peak_s;
  assign src_bus.dcmp = DIGITAL_CMP;
  assign src_bus.fault = fault_s;
  assign src_bus.acmp = acmp_s;

  //////////////////////////////////////////////////////////////////////////////
  // Source selection

  // Current-limit gate, seventeen-bit layout with peak current on top
  pfs_src_gate #(
    .WITH_PEAK(1'b1),
    .W(CLIM_W)
  ) u_clim_gate (
    .src(src_bus),
    .sel(clim_sel),
    .hit(clim_hit)
  );

  // A/B fault gate, fifteen-bit layout without peak current
  pfs_src_gate #(
    .WITH_PEAK(1'b0),
    .W(AB_W)
  ) u_ab_gate (
    .src(src_bus),
    .sel(ab_sel),
    .hit(ab_hit)
  );

  // Registered triggers towards the limit and fault responses
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CLIM_TRIG <= 1'b0;
      FAULT_AB_TRIG <= 1'b0;
    end else begin
      CLIM_TRIG <= clim_hit;
      FAULT_AB_TRIG <= ab_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Address decode of the write strobe
  assign wr_clim = WR && (ADDR == CLIM_OFS);
  assign wr_ab = WR && (ADDR == AB_OFS);
  assign wr_status = WR && (ADDR == INT_STATUS_OFS);
  assign wr_mask = WR && (ADDR == INT_MASK_OFS);

  // Current-limit select; the unused bit is never stored
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      clim_sel <= CLIM_RST;
    end else if (wr_clim) begin
      clim_sel <= WDATA[CLIM_W-1:0] & CLIM_WMASK;
    end
  end

  // A/B fault select
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ab_sel <= AB_RST;
    end else if (wr_ab) begin
      ab_sel <= WDATA[AB_W-1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_mask <= INT_RST;
    end else if (wr_mask) begin
      int_mask <= WDATA[INT_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status

  // Events are the rising edges of each trigger
  assign int_event[INT_CLIM_BIT] = clim_hit && !CLIM_TRIG;
  assign int_event[INT_AB_BIT] = ab_hit && !FAULT_AB_TRIG;
  assign int_clear = wr_status ? WDATA[INT_W-1:0] : INT_RST;

  // Sticky bits; a new event wins over a simultaneous clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_status <= INT_RST;
    end else begin
      int_status <= (int_status & ~int_clear) | int_event;
    end
  end

  // Level interrupt while any unmasked bit stands
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_status & int_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (RD) begin
      unique case (ADDR)
        CLIM_OFS: next_rdata = {15'h0000, clim_sel};
        AB_OFS: next_rdata = {17'h00000, ab_sel};
        INT_STATUS_OFS: next_rdata = {30'h0000_0000, int_status};
        INT_MASK_OFS: next_rdata = {30'h0000_0000, int_mask};
        SRC_STATE_OFS: next_rdata = {16'h0000, peak_s, DIGITAL_CMP, fault_s, acmp_s};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else begin
      RDATA <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  // Helper flags: has software ever written each select register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      clim_written <= 1'b0;
      ab_written <= 1'b0;
    end else begin
      if (wr_clim) begin
        clim_written <= 1'b1;
      end
      if (wr_ab) begin
        ab_written <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence clim_write_s;
    WR && (ADDR == CLIM_OFS);
  endsequence

  sequence clim_read_s;
    RD && (ADDR == CLIM_OFS);
  endsequence

  sequence ab_write_s;
    WR && (ADDR == AB_OFS);
  endsequence

  sequence ab_read_s;
    RD && (ADDR == AB_OFS);
  endsequence

  peak_gate_a: assert property (
    (clim_sel[CLIM_PEAK_BIT] && peak_s) |=> CLIM_TRIG
  ) else $error("peak current enabled but no current limit");

  peak_block_a: assert property (
    (!clim_sel[CLIM_PEAK_BIT] && peak_s && (clim_sel[CLIM_PEAK_BIT-1:0] == '0)) |=> !CLIM_TRIG
  ) else $error("disabled peak current caused a current limit");

  dcmp_clim_a: assert property (
    (|(clim_sel[CLIM_DCMP_LSB+3:CLIM_DCMP_LSB] & DIGITAL_CMP)) |=> CLIM_TRIG
  ) else $error("enabled digital comparator missed current limit");

  fault_clim_a: assert property (
    (|(clim_sel[CLIM_FAULT_LSB+3:CLIM_FAULT_LSB] & fault_s)) |=> CLIM_TRIG
  ) else $error("enabled fault input missed current limit");

  acmp_clim_a: assert property (
    (|(clim_sel[CLIM_ACMP_LSB+6:CLIM_ACMP_LSB] & acmp_s)) |=> CLIM_TRIG
  ) else $error("enabled analog comparator missed current limit");

  reserved_zero_a: assert property (
    clim_read_s |=> (RDATA[CLIM_RSVD_BIT] == 1'b0)
  ) else $error("reserved current-limit bit read as one");

  clim_reset_a: assert property (
    !clim_written |-> (clim_sel == CLIM_RST) && !CLIM_TRIG
  ) else $error("current-limit select not zero before first write");

  dcmp_ab_a: assert property (
    (|(ab_sel[AB_DCMP_LSB+3:AB_DCMP_LSB] & DIGITAL_CMP)) |=> FAULT_AB_TRIG
  ) else $error("enabled digital comparator missed A/B fault");

  fault_ab_a: assert property (
    (|(ab_sel[AB_FAULT_LSB+3:AB_FAULT_LSB] & fault_s)) |=> FAULT_AB_TRIG
  ) else $error("enabled fault input missed A/B fault");

  acmp_ab_a: assert property (
    (|(ab_sel[AB_ACMP_LSB+6:AB_ACMP_LSB] & acmp_s)) |=> FAULT_AB_TRIG
  ) else $error("enabled analog comparator missed A/B fault");

  ab_reset_a: assert property (
    !ab_written |-> (ab_sel == AB_RST) && !FAULT_AB_TRIG
  ) else $error("A/B fault select not zero before first write");

  clim_idle_a: assert property (
    ((clim_sel & {peak_s, DIGITAL_CMP, 1'b0, fault_s, acmp_s}) == '0) |=> !CLIM_TRIG
  ) else $error("current limit without an enabled source");

  ab_idle_a: assert property (
    ((ab_sel & {DIGITAL_CMP, fault_s, acmp_s}) == '0) |=> !FAULT_AB_TRIG
  ) else $error("A/B fault without an enabled source");

  clim_rdback_a: assert property (
    clim_write_s ##1 clim_read_s |=> (RDATA[CLIM_W-1:0] == ($past(WDATA[CLIM_W-1:0], 2) & CLIM_WMASK))
  ) else $error("current-limit select readback differs from write");

  ab_rdback_a: assert property (
    ab_write_s ##1 ab_read_s |=> (RDATA == {17'h00000, $past(WDATA[AB_W-1:0], 2)})
  ) else $error("A/B fault select readback differs from write");

  // A clear written in the cycle after the event may legally drop the bit
  sticky_set_a: assert property (
    (int_event[INT_CLIM_BIT] ##1 !wr_status) |-> int_status[INT_CLIM_BIT] [*2]
  ) else $error("current-limit event not held in status");

  irq_level_a: assert property (
    (|(int_status & int_mask)) |=> IRQ
  ) else $error("unmasked status did not raise interrupt");

endmodule : pfs_top

// >>> inc/pfs_pkg.sv
// Package of register map, field layout and reset values for the channel 3 source selection
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package pfs_pkg;
  // Register byte addresses
  localparam logic [31:0] CLIM_OFS = 32'h0003_0064;
  localparam logic [31:0] AB_OFS = 32'h0003_0068;
  localparam logic [31:0] INT_STATUS_OFS = 32'h0003_0080;
  localparam logic [31:0] INT_MASK_OFS = 32'h0003_0084;
  localparam logic [31:0] SRC_STATE_OFS = 32'h0003_0088;
  // Register widths
  localparam int CLIM_W = 17;
  localparam int AB_W = 15;
  localparam int INT_W = 2;
  localparam int SRC_W = 16;
  // Current-limit select field positions
  localparam int CLIM_PEAK_BIT = 16;
  localparam int CLIM_DCMP_LSB = 12;
  localparam int CLIM_RSVD_BIT = 11;
  localparam int CLIM_FAULT_LSB = 7;
  localparam int CLIM_ACMP_LSB = 0;
  // A/B fault select field positions
  localparam int AB_DCMP_LSB = 11;
  localparam int AB_FAULT_LSB = 7;
  localparam int AB_ACMP_LSB = 0;
  // Interrupt status and mask bit positions
  localparam int INT_CLIM_BIT = 0;
  localparam int INT_AB_BIT = 1;
  // Writable bits and reset values
  localparam logic [CLIM_W-1:0] CLIM_WMASK = 17'h1F7FF;
  localparam logic [CLIM_W-1:0] CLIM_RST = 17'h00000;
  localparam logic [AB_W-1:0] AB_RST = 15'h0000;
  localparam logic [INT_W-1:0] INT_RST = 2'h0;
endpackage : pfs_pkg

// >>> inc/pfs_src_if.sv
// Interface carrying the conditioned detection sources and the unsynchronised digital comparators to the selection gates
interface pfs_src_if;
  logic peak;
  logic [3:0] dcmp;
  logic [3:0] fault;
  logic [6:0] acmp;
  modport source (output peak, output dcmp, output fault, output acmp);
  modport sink (input peak, input dcmp, input fault, input acmp);
endinterface : pfs_src_if

// >>> verilog/pfs_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous source inputs
module pfs_sync
  import pfs_pkg::*;
#(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change only where stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule : pfs_sync

// >>> verilog/pfs_src_gate.sv
// Select gate: ANDs each source with its enable and ORs the results
module pfs_src_gate
  import pfs_pkg::*;
#(
  parameter bit WITH_PEAK = 1'b1,
  parameter int W = CLIM_W
) (
  pfs_src_if.sink src,
  input wire logic [W-1:0] sel,
  output logic hit
);
  logic [W-1:0] vec;

  // Arrange sources in the bit layout of the matching select register
  generate
    if (WITH_PEAK) begin : g_clim
      assign vec = {src.peak, src.dcmp, 1'b0, src.fault, src.acmp};
    end else begin : g_ab
      assign vec = {src.dcmp, src.fault, src.acmp};
    end
  endgenerate

  // Any enabled source raises the trigger
  assign hit = |(sel & vec);
endmodule : pfs_src_gate

// >>> testbench/pfs_top_test.sv
// Self-checking testbench for the channel 3 source selection block
module pfs_top_test
  import pfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic peak = 1'b0;
  logic [3:0] dcmp = 4'h0;
  logic [3:0] fault = 4'h0;
  logic [6:0] acmp = 7'h00;
  logic clim_trig;
  logic ab_trig;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  logic [31:0] rv;

  //////////////////////////////////////////////////////////////////////////////
  // Clock and design
  always #10 clk = ~clk;

  pfs_top dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PEAK_CURRENT_DET(peak), .DIGITAL_CMP(dcmp), .EXT_FAULT_IN(fault), .ANALOG_CMP(acmp),
    .CLIM_TRIG(clim_trig), .FAULT_AB_TRIG(ab_trig), .IRQ(irq));

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  // Write then read of one address with no idle cycle between the strobes
  task automatic bus_wr_rd(input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask : bus_wr_rd

  // Sources held long enough to pass the synchroniser and filter
  task automatic drive_src(input logic [15:0] v);
    @(posedge clk);
    peak <= v[15];
    dcmp <= v[14:11];
    fault <= v[10:7];
    acmp <= v[6:0];
    repeat (8) @(posedge clk);
    #1;
  endtask : drive_src

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  function automatic int clim_bit(input int i);
    return (i >= 11) ? i + 1 : i;
  endfunction : clim_bit

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [31:0] ofs [5];
    ofs = '{CLIM_OFS, AB_OFS, INT_STATUS_OFS, INT_MASK_OFS, SRC_STATE_OFS};
    for (int k = 0; k < 5; k++) begin
      bus_rd(ofs[k], rv);
      check(rv, 32'h0);
    end
    check({29'h0, clim_trig, ab_trig, irq}, 32'h0);
  endtask : t_reset

  task automatic t_regs();
    bus_wr_rd(CLIM_OFS, 32'hFFFFFFFF, rv);
    check(rv, 32'h0001F7FF);
    @(posedge clk);
    #1;
    check(rdata, 32'h0);
    bus_wr_rd(AB_OFS, 32'hFFFFFFFF, rv);
    check(rv, 32'h00007FFF);
    bus_wr(32'h00030070, 32'hFFFFFFFF);
    bus_rd(32'h00030070, rv);
    check(rv, 32'h0);
    bus_rd(AB_OFS, rv);
    check(rv, 32'h00007FFF);
    bus_wr(CLIM_OFS, 32'h00000800);
    bus_rd(CLIM_OFS, rv);
    check(rv, 32'h0);
    bus_wr(AB_OFS, 32'h0);
  endtask : t_regs

  // Each source alone, its enable alone, and all other sources against it
  task automatic t_sources();
    for (int i = 0; i < 16; i++) begin
      bus_wr(CLIM_OFS, 32'h1 << clim_bit(i));
      drive_src(16'h1 << i);
      check({31'h0, clim_trig}, 32'h1);
      check({31'h0, ab_trig}, 32'h0);
      bus_rd(SRC_STATE_OFS, rv);
      check(rv, 32'h1 << i);
      drive_src(~(16'h1 << i));
      check({31'h0, clim_trig}, 32'h0);
      bus_wr(CLIM_OFS, 32'h0);
      bus_wr(AB_OFS, (i < 15) ? (32'h1 << i) : 32'h7FFF);
      drive_src(16'h1 << i);
      check({31'h0, ab_trig}, (i < 15) ? 32'h1 : 32'h0);
      check({31'h0, clim_trig}, 32'h0);
      bus_wr(AB_OFS, 32'h0);
      drive_src(16'h0);
    end
  endtask : t_sources

  task automatic t_irq();
    bus_wr(INT_STATUS_OFS, 32'h3);
    bus_rd(INT_STATUS_OFS, rv);
    check(rv, 32'h0);
    bus_wr(INT_MASK_OFS, 32'h1);
    bus_wr(CLIM_OFS, 32'h00001000);
    drive_src(16'h0800);
    bus_rd(INT_STATUS_OFS, rv);
    check(rv, 32'h1);
    check({31'h0, irq}, 32'h1);
    bus_wr(INT_STATUS_OFS, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0);
    drive_src(16'h0);
    bus_wr(AB_OFS, 32'h00000800);
    drive_src(16'h0800);
    bus_rd(INT_STATUS_OFS, rv);
    check(rv, 32'h3);
    bus_wr(INT_MASK_OFS, 32'h2);
    bus_wr(INT_STATUS_OFS, 32'h2);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0);
    drive_src(16'h0);
  endtask : t_irq

  //////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_sources();
    t_irq();
    bus_wr(CLIM_OFS, 32'h0001F7FF);
    bus_wr(AB_OFS, 32'h00007FFF);
    do_reset();
    t_reset();
    finish_test();
  end

  // Watchdog well beyond the fewer than nine hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule : pfs_top_test
